//--- verilog/serial_pkg.sv
// Shared constants and types for the dual asynchronous serial ports
package serial_pkg;
	// Core clock and permitted baud range
	localparam int          CLK_HZ     = 100_000_000;
	localparam int          BAUD_MIN   = 300;
	localparam int          BAUD_MAX   = 600_000;
	localparam int          DIV_W      = 20;
	// Bit period in core cycles: fastest rate rounds down, slowest as well
	localparam logic [19:0] DIV_MIN    = 20'(CLK_HZ / BAUD_MAX);
	localparam logic [19:0] DIV_MAX    = 20'(CLK_HZ / BAUD_MIN);
	// Frame layout
	localparam int          DATA_BITS  = 8;
	localparam logic [2:0]  LAST_BIT   = 3'h7;
	localparam logic        START_LVL  = 1'b0;
	localparam logic        STOP_LVL   = 1'b1;
	localparam logic        IDLE_LVL   = 1'b1;
	// Receive buffer
	localparam logic [1:0]  BUF_DEPTH  = 2'h2;
	localparam int          PORTS      = 2;
	// Serialiser and deserialiser states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_START,
		ST_DATA,
		ST_STOP
	} bit_state_t;
endpackage

//--- verilog/serial_link_if.sv
// Four serial lines joining the device end and the host end
interface serial_link_if;
	logic port_zero_transmit;
	logic port_zero_receive;
	logic port_one_transmit;
	logic port_one_receive;

	// Device drives its transmit lines, host drives the device's receive lines
	modport device (
		output port_zero_transmit,
		output port_one_transmit,
		input  port_zero_receive,
		input  port_one_receive
	);
	modport host (
		input  port_zero_transmit,
		input  port_one_transmit,
		output port_zero_receive,
		output port_one_receive
	);
endinterface

//--- verilog/serial_device_end.sv
// Device end: one serial channel engine and the two-port device top
//
// Overview of operation
// R1 - Two independent ports, each with own lines
// R2 - Each port full duplex, 8-bit words
// R3 - Frame: eight data, no parity, one stop
// R4 - Per-port baud from 300 to 600K
// R5 - Single-byte or background buffered receive mode
// R6 - Start bit low, data, stop bit high
// R7 - Data bits go out least significant first
// R8 - Port zero serves loader until application runs
// R9 - Firmware image loads through port zero only
// R10 - Idle high; start edge; mid-bit sampling

module serial_channel (
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire logic [serial_pkg::DIV_W-1:0] div_sel,
	input  wire logic                      buffered,
	input  wire logic [7:0]                tx_data,
	input  wire logic                      tx_valid,
	output logic                           tx_ready,
	output logic                           line_tx,
	input  wire logic                      line_rx,
	output logic [7:0]                     rx_data,
	output logic                           rx_valid,
	input  wire logic                      rx_ready,
	output logic                           rx_overrun,
	output logic                           rx_frame_err
);
	logic [serial_pkg::DIV_W-1:0] period;
	logic [serial_pkg::DIV_W-1:0] half;
	serial_pkg::bit_state_t       tx_st;
	serial_pkg::bit_state_t       next_tx_st;
	logic [serial_pkg::DIV_W-1:0] tx_cnt;
	logic [serial_pkg::DIV_W-1:0] next_tx_cnt;
	logic [2:0]                   tx_bit;
	logic [2:0]                   next_tx_bit;
	logic [7:0]                   tx_shift;
	logic [7:0]                   next_tx_shift;
	logic                         next_line_tx;
	serial_pkg::bit_state_t       rx_st;
	serial_pkg::bit_state_t       next_rx_st;
	logic [serial_pkg::DIV_W-1:0] rx_cnt;
	logic [serial_pkg::DIV_W-1:0] next_rx_cnt;
	logic [2:0]                   rx_bit;
	logic [2:0]                   next_rx_bit;
	logic [7:0]                   rx_shift;
	logic [7:0]                   next_rx_shift;
	logic                         rx_prev;
	logic                         push;
	logic                         frame_bad;
	logic [7:0]                   ent [2];
	logic [7:0]                   next_ent [2];
	logic [1:0]                   occ;
	logic [1:0]                   next_occ;
	logic [1:0]                   occ_left;
	logic                         pop;
	logic                         accept;
	logic                         next_overrun;

	// Out-of-range divisors are clamped so a bad setting cannot stall a port
	always_comb begin
		if (div_sel < serial_pkg::DIV_MIN) begin
			period = serial_pkg::DIV_MIN; // [R4]
		end else if (div_sel > serial_pkg::DIV_MAX) begin
			period = serial_pkg::DIV_MAX; // [R4]
		end else begin
			period = div_sel;
		end
		half = period >> 1;
	end

	// Transmit serialiser next state
	always_comb begin
		next_tx_st    = tx_st;
		next_tx_cnt   = tx_cnt;
		next_tx_bit   = tx_bit;
		next_tx_shift = tx_shift;
		next_line_tx  = line_tx;
		case (tx_st)
			serial_pkg::ST_IDLE: begin
				next_line_tx = serial_pkg::IDLE_LVL; // [R10]
				if (tx_valid) begin
					next_tx_shift = tx_data;
					next_tx_cnt   = period - 1'b1;
					next_line_tx  = serial_pkg::START_LVL; // [R6]
					next_tx_st    = serial_pkg::ST_START;
				end
			end
			serial_pkg::ST_START: begin
				if (tx_cnt == '0) begin
					next_line_tx = tx_shift[0]; // [R7]
					next_tx_bit  = 3'h0;
					next_tx_cnt  = period - 1'b1;
					next_tx_st   = serial_pkg::ST_DATA;
				end else begin
					next_tx_cnt = tx_cnt - 1'b1;
				end
			end
			serial_pkg::ST_DATA: begin
				if (tx_cnt == '0) begin
					next_tx_cnt = period - 1'b1;
					if (tx_bit == serial_pkg::LAST_BIT) begin
						next_line_tx = serial_pkg::STOP_LVL; // [R3] [R6]
						next_tx_st   = serial_pkg::ST_STOP;
					end else begin
						next_tx_shift = tx_shift >> 1;
						next_line_tx  = tx_shift[1]; // [R7]
						next_tx_bit   = tx_bit + 1'b1;
					end
				end else begin
					next_tx_cnt = tx_cnt - 1'b1;
				end
			end
			serial_pkg::ST_STOP: begin
				if (tx_cnt == '0) begin
					next_tx_st = serial_pkg::ST_IDLE;
				end else begin
					next_tx_cnt = tx_cnt - 1'b1;
				end
			end
			default: begin
				next_tx_st   = serial_pkg::ST_IDLE;
				next_line_tx = serial_pkg::IDLE_LVL;
			end
		endcase
	end

	// Transmitter takes a byte only between frames
	assign tx_ready = (tx_st == serial_pkg::ST_IDLE); // [R2]

	// Transmit serialiser registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_st    <= serial_pkg::ST_IDLE;
			tx_cnt   <= '0;
			tx_bit   <= 3'h0;
			tx_shift <= 8'h00;
			line_tx  <= 1'b1;
		end else begin
			tx_st    <= next_tx_st;
			tx_cnt   <= next_tx_cnt;
			tx_bit   <= next_tx_bit;
			tx_shift <= next_tx_shift;
			line_tx  <= next_line_tx;
		end
	end

	// Receive deserialiser next state; runs alongside the transmitter
	always_comb begin
		next_rx_st    = rx_st;
		next_rx_cnt   = rx_cnt;
		next_rx_bit   = rx_bit;
		next_rx_shift = rx_shift;
		push          = 1'b0;
		frame_bad     = 1'b0;
		case (rx_st)
			serial_pkg::ST_IDLE: begin
				if (rx_prev && !line_rx) begin
					next_rx_cnt = half - 1'b1; // [R10]
					next_rx_st  = serial_pkg::ST_START;
				end
			end
			serial_pkg::ST_START: begin
				if (rx_cnt == '0) begin
					// A start bit gone high at mid-bit was a glitch
					if (line_rx == serial_pkg::START_LVL) begin
						next_rx_bit = 3'h0;
						next_rx_cnt = period - 1'b1;
						next_rx_st  = serial_pkg::ST_DATA;
					end else begin
						next_rx_st = serial_pkg::ST_IDLE;
					end
				end else begin
					next_rx_cnt = rx_cnt - 1'b1;
				end
			end
			serial_pkg::ST_DATA: begin
				if (rx_cnt == '0) begin
					next_rx_shift = {line_rx, rx_shift[7:1]}; // [R7] [R10]
					next_rx_cnt   = period - 1'b1;
					if (rx_bit == serial_pkg::LAST_BIT) begin
						next_rx_st = serial_pkg::ST_STOP; // [R3]
					end else begin
						next_rx_bit = rx_bit + 1'b1;
					end
				end else begin
					next_rx_cnt = rx_cnt - 1'b1;
				end
			end
			serial_pkg::ST_STOP: begin
				if (rx_cnt == '0) begin
					next_rx_st = serial_pkg::ST_IDLE;
					push       = (line_rx == serial_pkg::STOP_LVL); // [R3] [R6]
					frame_bad  = (line_rx != serial_pkg::STOP_LVL);
				end else begin
					next_rx_cnt = rx_cnt - 1'b1;
				end
			end
			default: begin
				next_rx_st = serial_pkg::ST_IDLE;
			end
		endcase
	end

	// Receive deserialiser registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_st        <= serial_pkg::ST_IDLE;
			rx_cnt       <= '0;
			rx_bit       <= 3'h0;
			rx_shift     <= 8'h00;
			rx_prev      <= 1'b1;
			rx_frame_err <= 1'b0;
		end else begin
			rx_st        <= next_rx_st;
			rx_cnt       <= next_rx_cnt;
			rx_bit       <= next_rx_bit;
			rx_shift     <= next_rx_shift;
			rx_prev      <= line_rx;
			rx_frame_err <= frame_bad;
		end
	end

	// Two-entry receive buffer; single-byte mode only accepts into an empty buffer
	always_comb begin
		pop         = rx_valid && rx_ready;
		occ_left    = occ - {1'b0, pop};
		accept      = push && (buffered ? (occ_left < serial_pkg::BUF_DEPTH)
		                                : (occ_left == 2'h0)); // [R5]
		next_ent[0] = pop ? ent[1] : ent[0];
		next_ent[1] = ent[1];
		if (accept) begin
			next_ent[occ_left[0]] = rx_shift;
		end
		next_occ     = occ_left + {1'b0, accept};
		next_overrun = push && !accept;
	end

	// Head entry drives the data output straight from a flop
	assign rx_valid = (occ != 2'h0);
	assign rx_data  = ent[0];

	// Receive buffer registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ent[0]     <= 8'h00;
			ent[1]     <= 8'h00;
			occ        <= 2'h0;
			rx_overrun <= 1'b0;
		end else begin
			ent[0]     <= next_ent[0];
			ent[1]     <= next_ent[1];
			occ        <= next_occ;
			rx_overrun <= next_overrun;
		end
	end
endmodule

module serial_device_end (
	input  wire logic                         CORE_CLK,
	input  wire logic                         RST_N,
	serial_link_if.device                     LINK,
	input  wire logic [1:0][serial_pkg::DIV_W-1:0] BAUD_DIV,
	input  wire logic [1:0]                   BUFFERED,
	input  wire logic [1:0][7:0]              TX_DATA,
	input  wire logic [1:0]                   TX_VALID,
	output logic [1:0]                        TX_READY,
	output logic [1:0][7:0]                   RX_DATA,
	output logic [1:0]                        RX_VALID,
	input  wire logic [1:0]                   RX_READY,
	output logic [1:0]                        RX_OVERRUN,
	output logic [1:0]                        RX_FRAME_ERR,
	input  wire logic                         APP_RUNNING,
	input  wire logic [7:0]                   LOADER_TX_DATA,
	input  wire logic                         LOADER_TX_VALID,
	output logic                              LOADER_TX_READY,
	output logic [7:0]                        LOADER_RX_DATA,
	output logic                              LOADER_RX_VALID,
	input  wire logic                         LOADER_RX_READY
);
	logic [1:0]      boot;
	logic [1:0]      line_tx;
	logic [1:0]      line_rx;
	logic [1:0][7:0] ch_tx_data;
	logic [1:0]      ch_tx_valid;
	logic [1:0]      ch_tx_ready;
	logic [1:0]      ch_rx_valid;
	logic [1:0]      ch_rx_ready;
	logic [1:0]      ch_buffered;

	// Only port zero is ever handed to the loader
	assign boot = {1'b0, ~APP_RUNNING}; // [R8] [R9]

	// Line mapping onto the link
	assign LINK.port_zero_transmit = line_tx[0];
	assign LINK.port_one_transmit  = line_tx[1];
	assign line_rx                 = {LINK.port_one_receive, LINK.port_zero_receive};

	// Loader handshake rides on port zero while booting
	assign LOADER_TX_READY = boot[0] & ch_tx_ready[0]; // [R8]
	assign LOADER_RX_VALID = boot[0] & ch_rx_valid[0]; // [R8] [R9]
	assign LOADER_RX_DATA  = RX_DATA[0];

	// One independent channel per port
	for (genvar i = 0; i < serial_pkg::PORTS; i++) begin : g_port
		// Boot forces buffering, so the loader can hold up to two unread bytes
		assign ch_buffered[i] = BUFFERED[i] | boot[i];
		assign ch_tx_data[i]  = boot[i] ? LOADER_TX_DATA : TX_DATA[i];
		assign ch_tx_valid[i] = boot[i] ? LOADER_TX_VALID : TX_VALID[i];
		assign ch_rx_ready[i] = boot[i] ? LOADER_RX_READY : RX_READY[i];
		assign TX_READY[i]    = ~boot[i] & ch_tx_ready[i]; // [R8]
		assign RX_VALID[i]    = ~boot[i] & ch_rx_valid[i]; // [R8]

		serial_channel u_chan ( // [R1] [R2]
			.clk          (CORE_CLK),
			.rst_n        (RST_N),
			.div_sel      (BAUD_DIV[i]),
			.buffered     (ch_buffered[i]),
			.tx_data      (ch_tx_data[i]),
			.tx_valid     (ch_tx_valid[i]),
			.tx_ready     (ch_tx_ready[i]),
			.line_tx      (line_tx[i]),
			.line_rx      (line_rx[i]),
			.rx_data      (RX_DATA[i]),
			.rx_valid     (ch_rx_valid[i]),
			.rx_ready     (ch_rx_ready[i]),
			.rx_overrun   (RX_OVERRUN[i]),
			.rx_frame_err (RX_FRAME_ERR[i])
		);
	end
endmodule

//--- verilog/serial_host_end.sv
// Host end: the external controller driving both serial ports
module serial_host_end (
	input  wire logic                         CORE_CLK,
	input  wire logic                         RST_N,
	serial_link_if.host                       LINK,
	input  wire logic [1:0][serial_pkg::DIV_W-1:0] BAUD_DIV,
	input  wire logic [1:0][7:0]              TX_DATA,
	input  wire logic [1:0]                   TX_VALID,
	output logic [1:0]                        TX_READY,
	output logic [1:0][7:0]                   RX_DATA,
	output logic [1:0]                        RX_VALID,
	input  wire logic [1:0]                   RX_READY,
	output logic [1:0]                        RX_OVERRUN,
	output logic [1:0]                        RX_FRAME_ERR
);
	logic [1:0] line_tx;
	logic [1:0] line_rx;

	// Host transmits into the device's receive lines; same rate and format as the device
	assign LINK.port_zero_receive = line_tx[0]; // [R3] [R4]
	assign LINK.port_one_receive  = line_tx[1];
	assign line_rx                = {LINK.port_one_transmit, LINK.port_zero_transmit};

	// Host always buffers; firmware bytes are just data sent on port zero
	for (genvar i = 0; i < serial_pkg::PORTS; i++) begin : g_port
		serial_channel u_chan ( // [R6] [R7] [R10]
			.clk          (CORE_CLK),
			.rst_n        (RST_N),
			.div_sel      (BAUD_DIV[i]),
			.buffered     (1'b1),
			.tx_data      (TX_DATA[i]),
			.tx_valid     (TX_VALID[i]),
			.tx_ready     (TX_READY[i]),
			.line_tx      (line_tx[i]),
			.line_rx      (line_rx[i]),
			.rx_data      (RX_DATA[i]),
			.rx_valid     (RX_VALID[i]),
			.rx_ready     (RX_READY[i]),
			.rx_overrun   (RX_OVERRUN[i]),
			.rx_frame_err (RX_FRAME_ERR[i])
		);
	end
endmodule

//--- sim/serial_props.sv
// Checker on the four serial lines between the two ends
module serial_props #(
	parameter int DIV = 166
) (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic port_zero_transmit,
	input wire logic port_one_transmit,
	input wire logic port_zero_receive,
	input wire logic port_one_receive
);
	localparam int DL   = DIV - 1;
	localparam int LAST = 10 * DIV - 1;
	logic [3:0] ln;
	logic [3:0] prev;
	logic [3:0] next_prev;
	int         pos [4];
	int         next_pos [4];
	// Transmit lines at 0..1, receive lines at 2..3
	assign ln = {port_one_receive, port_zero_receive, port_one_transmit, port_zero_transmit};
	// Sample index within the frame, 0 while idle; drops to 0 after the last stop sample, then waits for the next fall
	always_comb begin
		next_prev = ln;
		for (int i = 0; i < 4; i++) begin
			if (pos[i] == 0)
				next_pos[i] = (prev[i] && !ln[i]) ? 1 : 0;
			else
				next_pos[i] = (pos[i] == LAST) ? 0 : pos[i] + 1;
		end
	end
	// Registered trackers
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			prev <= 4'hF;
			pos  <= '{default: 0};
		end else begin
			prev <= next_prev;
			pos  <= next_pos;
		end
	end
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	// A start is a fall seen while idle
	sequence s_start(int i);
		pos[i] == 0 && prev[i] && !ln[i];
	endsequence
	property p_start_held(int i);
		s_start(i) |-> ##DL !ln[i];
	endproperty
	property p_bit_steady(int i);
		pos[i] > 0 && pos[i] < 9 * DIV && pos[i] % DIV != 0 |-> $stable(ln[i]);
	endproperty
	property p_stop_high(int i);
		pos[i] >= 9 * DIV |-> ln[i];
	endproperty
	property p_idle_high(int i);
		pos[i] == 0 && !ln[i] |-> prev[i];
	endproperty
	// Lines driven by the device end
	for (genvar i = 0; i < 2; i++) begin : g_tx
		a_tx_start_held: assert property (p_start_held(i)) else $error("Short start bit");
		a_tx_bit_steady: assert property (p_bit_steady(i)) else $error("Bit moved");
		a_tx_stop_high: assert property (p_stop_high(i)) else $error("Stop bit low");
		a_tx_idle_high: assert property (p_idle_high(i)) else $error("Idle line low");
	end
	// Lines driven by the host end
	for (genvar i = 2; i < 4; i++) begin : g_rx
		a_rx_start_held: assert property (p_start_held(i)) else $error("Short start bit");
		a_rx_bit_steady: assert property (p_bit_steady(i)) else $error("Bit moved");
		a_rx_stop_high: assert property (p_stop_high(i)) else $error("Stop bit low");
		a_rx_idle_high: assert property (p_idle_high(i)) else $error("Idle line low");
	end
endmodule

//--- sim/tb_top.sv
// Bench: device end and host end joined through the serial link
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int P = 166;
	typedef struct packed {
		logic       p;
		logic [7:0] db;
		logic [7:0] hb;
	} row_t;
	// Index 2e+p: device user 0..1, host 2..3, loader 4
	logic [4:0]                        tv;
	logic [4:0]                        rr;
	logic [4:0][7:0]                   td;
	wire  [4:0]                        tr;
	wire  [4:0]                        rv;
	wire  [4:0][7:0]                   rd;
	wire  [3:0]                        ov;
	wire  [3:0]                        fe;
	logic                              clk;
	logic                              rst_n;
	logic                              app;
	logic [1:0]                        dbuf;
	logic [1:0][serial_pkg::DIV_W-1:0] div;
	int                                bad_count = 0;
	int                                n_tests = 0;
	int                                cyc = 0;
	int                                ovn = 0;
	int                                fen = 0;
	int                                base;
	row_t                              rows [5] = '{'{1'b0, 8'h00, 8'hFF},
		'{1'b1, 8'hFF, 8'h00}, '{1'b0, 8'hA5, 8'h5A}, '{1'b1, 8'h01, 8'h80},
		'{1'b1, 8'h3C, 8'hC3}};
	serial_link_if serial_link_if_i ();
	serial_device_end serial_device_end_i (
		.CORE_CLK(clk), .RST_N(rst_n), .LINK(serial_link_if_i), .BAUD_DIV(div),
		.BUFFERED(dbuf), .TX_DATA(td[1:0]), .TX_VALID(tv[1:0]), .TX_READY(tr[1:0]),
		.RX_DATA(rd[1:0]), .RX_VALID(rv[1:0]), .RX_READY(rr[1:0]), .RX_OVERRUN(ov[1:0]),
		.RX_FRAME_ERR(fe[1:0]), .APP_RUNNING(app), .LOADER_TX_DATA(td[4]),
		.LOADER_TX_VALID(tv[4]), .LOADER_TX_READY(tr[4]), .LOADER_RX_DATA(rd[4]),
		.LOADER_RX_VALID(rv[4]), .LOADER_RX_READY(rr[4]));
	serial_host_end serial_host_end_i (
		.CORE_CLK(clk), .RST_N(rst_n), .LINK(serial_link_if_i), .BAUD_DIV(div),
		.TX_DATA(td[3:2]), .TX_VALID(tv[3:2]), .TX_READY(tr[3:2]), .RX_DATA(rd[3:2]),
		.RX_VALID(rv[3:2]), .RX_READY(rr[3:2]), .RX_OVERRUN(ov[3:2]),
		.RX_FRAME_ERR(fe[3:2]));
	serial_props #(.DIV(P)) serial_props_i (
		.CORE_CLK(clk), .RST_N(rst_n),
		.port_zero_transmit(serial_link_if_i.port_zero_transmit),
		.port_one_transmit(serial_link_if_i.port_one_transmit),
		.port_zero_receive(serial_link_if_i.port_zero_receive),
		.port_one_receive(serial_link_if_i.port_one_receive));
	// Core clock
	always #5 clk = ~clk;
	// Hang guard, well above the longest expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 80000) begin
			bad_count++;
			conclude();
		end
	end
	// Pulses counted on the falling edge, clear of the edge that launches them
	always @(negedge clk) begin
		ovn += ov[0] + ov[1] + ov[2] + ov[3];
		fen += |fe;
	end
	function automatic logic lvl(input int k);
		case (k)
			1: return serial_link_if_i.port_one_transmit;
			2: return serial_link_if_i.port_zero_receive;
			3: return serial_link_if_i.port_one_receive;
			default: return serial_link_if_i.port_zero_transmit;
		endcase
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Hold valid until taken; optionally sample the line at every mid-bit
	task automatic send(input int k, input logic [7:0] b, input logic w);
		int          n;
		logic [10:0] fr;
		n = 0;
		fr = {2'b11, b, 1'b0};
		td[k] = b;
		tv[k] = 1'b1;
		while (tr[k] !== 1'b1 && n < 4000) begin
			@(posedge clk);
			#1;
			n++;
		end
		// A port that never frees up is a failure, not a silent skip
		if (tr[k] !== 1'b1)
			bad_count++;
		@(posedge clk);
		#1;
		tv[k] = 1'b0;
		if (w) begin
			repeat (P / 2) @(posedge clk);
			for (int i = 0; i < 11; i++) begin
				#1;
				check(8'(lvl(k)), 8'(fr[i]));
				repeat (P) @(posedge clk);
			end
			#1;
		end else begin
			// Let an edge pass so a following call never re-raises valid in this step
			@(posedge clk);
			#1;
		end
	endtask
	// Wait for a byte, compare it, pop it
	task automatic recv(input int k, input logic [7:0] b);
		int n;
		n = 0;
		while (rv[k] !== 1'b1 && n < 4000) begin
			@(posedge clk);
			#1;
			n++;
		end
		// Stale head data must not pass for a byte that never came
		if (rv[k] !== 1'b1)
			bad_count++;
		check(rd[k], b);
		rr[k] = 1'b1;
		@(posedge clk);
		#1;
		rr[k] = 1'b0;
		// Keep ready low across one edge before the next pop
		@(posedge clk);
		#1;
	endtask
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		app = 1'b1;
		dbuf = 2'h3;
		tv = 5'h00;
		rr = 5'h00;
		td = '0;
		div = {2{20'h0_00A6}};
		repeat (6) @(posedge clk);
		#1;
		rst_n = 1'b1;
		// Table: both directions at once on the row's port
		foreach (rows[i]) begin
			fork
				send(rows[i].p, rows[i].db, 1'b1);
				send(2 + rows[i].p, rows[i].hb, 1'b1);
			join
			recv(2 + rows[i].p, rows[i].db);
			recv(rows[i].p, rows[i].hb);
		end
		// Buffered: two held, third dropped, order kept
		base = ovn;
		send(3, 8'h11, 1'b0);
		send(3, 8'h22, 1'b0);
		send(3, 8'h33, 1'b0);
		repeat (11 * P) @(posedge clk);
		#1;
		check(8'(ovn - base), 8'h01);
		recv(1, 8'h11);
		recv(1, 8'h22);
		check(8'(rv[1]), 8'h00);
		// Single byte: second arrival dropped
		dbuf[0] = 1'b0;
		base = ovn;
		send(2, 8'h44, 1'b0);
		send(2, 8'h55, 1'b0);
		repeat (11 * P) @(posedge clk);
		#1;
		check(8'(ovn - base), 8'h01);
		recv(0, 8'h44);
		check(8'(rv[0]), 8'h00);
		dbuf[0] = 1'b1;
		// Boot: port zero belongs to the loader, port one stays with the user
		app = 1'b0;
		@(posedge clk);
		#1;
		check(8'(tr[0]), 8'h00);
		send(2, 8'h5A, 1'b0);
		recv(4, 8'h5A);
		check(8'(rv[0]), 8'h00);
		send(4, 8'hC3, 1'b1);
		recv(2, 8'hC3);
		send(3, 8'h69, 1'b0);
		recv(1, 8'h69);
		app = 1'b1;
		// Reset in mid-run, then traffic again
		rst_n = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		check(8'({serial_link_if_i.port_one_transmit, serial_link_if_i.port_zero_transmit,
			tr[3:0]}), 8'h3F);
		check(8'(rv), 8'h00);
		// Divisor below the minimum must clamp to the fastest legal rate
		div = '0;
		rst_n = 1'b1;
		send(1, 8'h96, 1'b1);
		recv(3, 8'h96);
		check(8'(fen), 8'h00);
		conclude();
	end
endmodule
